// [asrc_pkg.sv]
// Constants for the status and rate/filter register pair of the converter.
// Assumes a decoded register-command port from the serial command front end.
package asrc_pkg;
  localparam int ASRC_AW = 5;
  localparam int ASRC_DW = 8;
  localparam logic [4:0] ASRC_ADDR_STATUS = 5'h01;
  localparam logic [4:0] ASRC_ADDR_RATECFG = 5'h02;
  localparam logic [7:0] ASRC_STATUS_RST = 8'h01;
  localparam logic [7:0] ASRC_RATECFG_RST = 8'h24;
  localparam int ASRC_B_LOCK = 7;
  localparam int ASRC_B_CHK = 6;
  localparam int ASRC_B_AMPL = 5;
  localparam int ASRC_B_AMPH = 4;
  localparam int ASRC_B_VREFL = 3;
  localparam int ASRC_B_NEW = 2;
  localparam int ASRC_B_CLK = 1;
  localparam int ASRC_B_RST = 0;
  localparam logic [4:0] ASRC_RATE_MAXCODE = 5'h10;
  localparam int ASRC_RATE_LSB = 3;
  localparam logic [2:0] ASRC_FILT_FIR = 3'h4;
  localparam logic [7:0] ASRC_UNMAPPED = 8'h00;
endpackage

// [asrc_sync3.sv]
// Three-stage synchroniser plus an output flop for asynchronous pin levels.
// Assumes one system clock; output changes when stages two and three agree.
`timescale 1ns/1ns
module asrc_sync3 #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  ////////////////////////////////////////////////////////////////////////////
  // Stage one is read only by stage two, against metastability
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          dout[i] <= stage3[i];
        end
      end
    end
  end
endmodule

// [asrc_regs.sv]
// Status and rate/filter register pair of a delta-sigma converter.
// Assumes a command decoder on clk delivering one-cycle register command
// strobes, and analog monitor / clock-detect levels arriving asynchronously.
`timescale 1ns/1ns
module asrc_regs (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic regReadCmd,
  input wire logic regWriteCmd,
  input wire logic [asrc_pkg::ASRC_AW-1:0] regAddr,
  input wire logic [asrc_pkg::ASRC_DW-1:0] regWrData,
  input wire logic lockCmd,
  input wire logic unlockCmd,
  input wire logic checkFault,
  input wire logic convStart,
  input wire logic convDone,
  input wire logic dataRead,
  input wire logic ampLowPin,
  input wire logic ampHighPin,
  input wire logic vrefLowPin,
  input wire logic extClockPin,
  output logic [asrc_pkg::ASRC_DW-1:0] regRdData,
  output logic regRdValid,
  output logic [4:0] rateSelect,
  output logic [2:0] filterSelect,
  output logic rateIsMax,
  output logic convRestart
);
  import asrc_pkg::*;

  logic writeLock;
  logic checkFaultFlag;
  logic ampLowAlarm;
  logic ampHighAlarm;
  logic vrefLowAlarm;
  logic newSampleFlag;
  logic resetFlag;
  logic [3:0] monSync;
  logic [7:0] rateFilterConfig;
  logic [7:0] statusValue;
  logic wrOk;
  logic wrStatus;
  logic wrRate;

  ////////////////////////////////////////////////////////////////////////////
  // Pin levels cross into clk through four flops (three stages and the output flop)
  asrc_sync3 #(.WIDTH(4)) uSync (
    .clk(clk),
    .rst_n(rst_n),
    .din({extClockPin, vrefLowPin, ampHighPin, ampLowPin}),
    .dout(monSync)
  );

  // Write qualification; lock blocks writes, never reads
  assign wrOk = regWriteCmd && !writeLock;
  assign wrStatus = wrOk && (regAddr == ASRC_ADDR_STATUS);
  assign wrRate = wrOk && (regAddr == ASRC_ADDR_RATECFG);

  ////////////////////////////////////////////////////////////////////////////
  // Lock state; unlock wins if both arrive together
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      writeLock <= 1'b0;
    end else if (unlockCmd) begin
      writeLock <= 1'b0;
    end else if (lockCmd) begin
      writeLock <= 1'b1;
    end
  end

  // Sticky check fault; a new fault beats a host clear in the same cycle
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      checkFaultFlag <= 1'b0;
    end else if (checkFault) begin
      checkFaultFlag <= 1'b1;
    end else if (wrStatus) begin
      checkFaultFlag <= regWrData[ASRC_B_CHK];
    end
  end

  // Reset indicator; only the host can bring it to zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      resetFlag <= 1'b1;
    end else if (wrStatus) begin
      resetFlag <= regWrData[ASRC_B_RST];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarms latch the monitor and clear at conversion start; a monitor still
  // asserted at start re-sets the bit, so a standing fault is never hidden
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ampLowAlarm <= 1'b0;
      ampHighAlarm <= 1'b0;
      vrefLowAlarm <= 1'b0;
    end else begin
      ampLowAlarm <= monSync[0] | (ampLowAlarm & ~convStart);
      ampHighAlarm <= monSync[1] | (ampHighAlarm & ~convStart);
      vrefLowAlarm <= monSync[2] | (vrefLowAlarm & ~convStart);
    end
  end

  // New result flag; completion beats a simultaneous data read
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      newSampleFlag <= 1'b0;
    end else if (convDone) begin
      newSampleFlag <= 1'b1;
    end else if (dataRead) begin
      newSampleFlag <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate/filter register and restart strobe on any accepted write to the rate/filter address
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rateFilterConfig <= ASRC_RATECFG_RST;
      convRestart <= 1'b0;
    end else begin
      convRestart <= wrRate;
      if (wrRate) begin
        rateFilterConfig <= regWrData;
      end
    end
  end

  // Decoded configuration outputs, registered
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rateSelect <= ASRC_RATECFG_RST[ASRC_DW-1:ASRC_RATE_LSB];
      filterSelect <= ASRC_RATECFG_RST[ASRC_RATE_LSB-1:0];
      rateIsMax <= 1'b0;
    end else begin
      rateSelect <= rateFilterConfig[ASRC_DW-1:ASRC_RATE_LSB];
      filterSelect <= rateFilterConfig[ASRC_RATE_LSB-1:0];
      rateIsMax <= rateFilterConfig[ASRC_DW-1:ASRC_RATE_LSB] >= ASRC_RATE_MAXCODE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status byte assembly
  always_comb begin
    statusValue = '0;
    statusValue[ASRC_B_LOCK] = writeLock;
    statusValue[ASRC_B_CHK] = checkFaultFlag;
    statusValue[ASRC_B_AMPL] = ampLowAlarm;
    statusValue[ASRC_B_AMPH] = ampHighAlarm;
    statusValue[ASRC_B_VREFL] = vrefLowAlarm;
    statusValue[ASRC_B_NEW] = newSampleFlag;
    statusValue[ASRC_B_CLK] = monSync[3];
    statusValue[ASRC_B_RST] = resetFlag;
  end

  // Read port; served regardless of lock, unmapped reads return zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      regRdData <= '0;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regReadCmd;
      if (regReadCmd) begin
        case (regAddr)
          ASRC_ADDR_STATUS: regRdData <= statusValue;
          ASRC_ADDR_RATECFG: regRdData <= rateFilterConfig;
          default: regRdData <= ASRC_UNMAPPED;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks; all watch state the design drives, clocked on clk
  // Lock behaviour: locked writes leave no trace, commands take one cycle
  AST_LOCK_BLOCKS_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    writeLock && regWriteCmd && regAddr == ASRC_ADDR_RATECFG
    |=> $stable(rateFilterConfig) && !convRestart)
    else $error("write accepted while locked");
  AST_LOCK_SET: assert property (@(posedge clk) disable iff (!rst_n)
    lockCmd && !unlockCmd |=> writeLock)
    else $error("lock not reported");
  AST_LOCK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    unlockCmd |=> !writeLock)
    else $error("unlock not reported");
  // Check fault stays set until a host write of zero with no new fault
  AST_CHK_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    checkFault || (checkFaultFlag && !wrStatus) |=> checkFaultFlag)
    else $error("check fault lost");
  AST_CHK_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    wrStatus && !checkFault && !regWrData[ASRC_B_CHK] |=> !checkFaultFlag)
    else $error("check fault not cleared by host");
  // Alarms: set from the synchronised monitor, dropped only at a start
  AST_ALARM_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    convStart && !monSync[0] |=> !ampLowAlarm)
    else $error("low alarm not cleared at start");
  AST_HIGH_ALARM: assert property (@(posedge clk) disable iff (!rst_n)
    monSync[1] |=> ampHighAlarm)
    else $error("high alarm not set");
  AST_VREF_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    vrefLowAlarm && !convStart |=> vrefLowAlarm)
    else $error("reference alarm dropped early");
  // New result flag: completion sets, a lone data read clears
  AST_NEW_SAMPLE: assert property (@(posedge clk) disable iff (!rst_n)
    convDone |=> newSampleFlag)
    else $error("new sample flag not set");
  AST_NEW_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    dataRead && !convDone |=> !newSampleFlag)
    else $error("new sample flag not cleared by read");
  // Reset indicator moves only on a host write or a reset
  AST_RESET_FLAG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !wrStatus |=> $stable(resetFlag))
    else $error("reset indicator changed without a write");
  // Configuration write, its restart strobe and the decoded copies
  AST_RESTART: assert property (@(posedge clk) disable iff (!rst_n)
    wrRate |=> convRestart && rateFilterConfig == $past(regWrData))
    else $error("rate write did not restart");
  AST_RATE_MAX: assert property (@(posedge clk) disable iff (!rst_n)
    rateIsMax == (rateSelect >= ASRC_RATE_MAXCODE))
    else $error("maximum rate flag disagrees with rate code");
  // Read port answers every read one cycle later, locked or not
  AST_RD_VALID: assert property (@(posedge clk) disable iff (!rst_n)
    regReadCmd |=> regRdValid)
    else $error("read not answered");
  AST_RD_PULSE: assert property (@(posedge clk) disable iff (!rst_n)
    !regReadCmd |=> !regRdValid)
    else $error("read valid without a read");
  AST_RD_STATUS: assert property (@(posedge clk) disable iff (!rst_n)
    regReadCmd && regAddr == ASRC_ADDR_STATUS |=> regRdData == $past(statusValue))
    else $error("status read returned wrong byte");
  // Reset values, with no disable so that reset itself is covered
  AST_RESET_VAL: assert property (@(posedge clk)
    !rst_n |=> rateFilterConfig == ASRC_RATECFG_RST && resetFlag && !writeLock)
    else $error("reset values wrong");
endmodule

// [asrc_host_model.sv]
// Host model issuing one-byte register and lock commands.
// Assumes the bench calls its tasks one at a time on clk.
`timescale 1ns/1ns
module asrc_host_model (
  input wire logic clk,
  output logic regReadCmd,
  output logic regWriteCmd,
  output logic [4:0] regAddr,
  output logic [7:0] regWrData,
  output logic lockCmd,
  output logic unlockCmd
);
  ////////////////////////////////////////////////////////////////////////
  // Idle bus; address and data hold a junk pattern while unused
  initial begin
    {regReadCmd, regWriteCmd, lockCmd, unlockCmd} = 4'h0;
    regAddr = 5'h1f;
    regWrData = 8'ha5;
  end
  // One byte per command, 5-bit address; inverted once released
  task automatic cmd(input logic wr, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    regReadCmd <= !wr;
    regWriteCmd <= wr;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    {regReadCmd, regWriteCmd} <= 2'h0;
    regAddr <= ~a;
    regWrData <= ~d;
  endtask
  // Lock or unlock, one-cycle strobe
  task automatic lock(input logic on);
    @(posedge clk);
    lockCmd <= on;
    unlockCmd <= !on;
    @(posedge clk);
    {lockCmd, unlockCmd} <= 2'h0;
  endtask
endmodule

// [adc_status_and_rate_config_test.sv]
// Self-checking bench for the status and rate/filter register pair.
// Assumes asrc_regs and the host model; events and pins driven here.
`timescale 1ns/1ns
module adc_status_and_rate_config_test;
  import asrc_pkg::*;
  logic clk = 0, rst_n = 0, rs;
  logic [3:0] ev = 4'h0, pin = 4'h0;
  logic regReadCmd, regWriteCmd, lockCmd, unlockCmd, regRdValid, rateIsMax, convRestart;
  logic [4:0] regAddr, rateSelect;
  logic [7:0] regWrData, regRdData, rd;
  logic [2:0] filterSelect;
  int err_total = 0, n_checks = 0;
  localparam logic [4:0] RC [5] = '{5'h00, 5'h07, 5'h0f, 5'h10, 5'h1f};
  ////////////////////////////////////////////////////////////////////////
  // Clock, 40 ns period
  always #20 clk = ~clk;
  asrc_host_model host (.clk, .regReadCmd, .regWriteCmd, .regAddr, .regWrData,
    .lockCmd, .unlockCmd);
  asrc_regs uut (.clk, .rst_n, .regReadCmd, .regWriteCmd, .regAddr, .regWrData,
    .lockCmd, .unlockCmd, .checkFault(ev[0]), .convStart(ev[1]), .convDone(ev[2]),
    .dataRead(ev[3]), .ampLowPin(pin[0]), .ampHighPin(pin[1]), .vrefLowPin(pin[2]),
    .extClockPin(pin[3]), .regRdData, .regRdValid, .rateSelect, .filterSelect,
    .rateIsMax, .convRestart);
  ////////////////////////////////////////////////////////////////////////
  // Compare and closing report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Read waits for the valid pulse under a bound; a miss ends the run
  task automatic rdreg(input logic [4:0] a);
    int i;
    host.cmd(1'b0, a, 8'h00);
    #1;
    i = 0;
    while (regRdValid !== 1'b1 && i < 4) begin
      @(posedge clk);
      #1;
      i++;
    end
    if (regRdValid !== 1'b1) begin
      err_total++;
      $display("[FAIL] t=%0t got %h exp %h", $time, regRdValid, 1'b1);
      stop_test;
    end else begin
      rd = regRdData;
    end
  endtask
  // Write; restart pulse sampled in the cycle it stands
  task automatic wrreg(input logic [4:0] a, input logic [7:0] d);
    host.cmd(1'b1, a, d);
    #1;
    rs = convRestart;
  endtask
  task automatic pulse(input logic [3:0] m);
    @(posedge clk) ev <= m;
    @(posedge clk) ev <= 4'h0;
  endtask
  task automatic settle(input logic [3:0] p);
    @(posedge clk) pin <= p;
    repeat (8) @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h01);
    rdreg(ASRC_ADDR_RATECFG);
    chk(rd, 8'h24);
    chk({rateSelect, filterSelect}, 8'h24);
    rdreg(5'h1f);
    chk(rd, 8'h00);
  endtask
  // Rate boundaries with every legal filter code; reserved codes never sent
  task automatic t_rates;
    logic [7:0] d;
    for (int i = 0; i < 5; i++) begin
      d = {RC[i], 3'(i)};
      wrreg(ASRC_ADDR_RATECFG, d);
      chk({7'h0, rs}, 8'h01);
      rdreg(ASRC_ADDR_RATECFG);
      chk(rd, d);
      chk({rateSelect, filterSelect}, d);
      chk({7'h0, rateIsMax}, {7'h0, d[7]});
    end
  endtask
  // Each alarm on its own pin, so a swapped bit is caught
  task automatic t_status;
    wrreg(ASRC_ADDR_STATUS, 8'h00);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h00);
    pulse(4'h1);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h40);
    wrreg(ASRC_ADDR_STATUS, 8'hff);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h41);
    wrreg(ASRC_ADDR_STATUS, 8'h00);
    settle(4'h1);
    settle(4'h0);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h20);
    settle(4'h2);
    settle(4'h0);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h30);
    settle(4'h4);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h38);
    pulse(4'h2);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h08);
    settle(4'h0);
    pulse(4'h2);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h00);
    pulse(4'h4);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h04);
    pulse(4'hc);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h04);
    pulse(4'h8);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h00);
    settle(4'h8);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h02);
    settle(4'h0);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h00);
  endtask
  // Lock blocks writes, reads still served; reset while locked mid-run
  task automatic t_lock;
    host.lock(1'b1);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h80);
    wrreg(ASRC_ADDR_RATECFG, 8'h0b);
    chk({7'h0, rs}, 8'h00);
    wrreg(ASRC_ADDR_STATUS, 8'h01);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h80);
    rdreg(ASRC_ADDR_RATECFG);
    chk(rd, 8'hfc);
    host.lock(1'b0);
    rdreg(ASRC_ADDR_STATUS);
    chk(rd, 8'h00);
    host.lock(1'b1);
    @(posedge clk) rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_rates;
    t_status;
    t_lock;
    stop_test;
  end
endmodule
